// file: rtl/asct_serial_port.sv
// serial command port of the converter with command timing
// Notes on behaviour
// - data out is released to high impedance as soon as chip select goes high.
// - a calibration takes 7 conversion periods and no command is taken meanwhile.
// - a reset pattern starts only with a first high pulse of 300 to 500 osc periods.
// - low gaps in the reset pattern last at least 5 osc periods and separate pulses.
// - the second high pulse lasts 550 to 750 osc periods or the pattern is dropped.
// - a third high pulse of 1050 to 1250 osc periods completes the pattern.
// - conversion ready goes low when a calibration completes.
// - a low level on the reset pin resets serial and configuration state.
`timescale 1ns/1ps
`default_nettype none
module asct_serial_port
   import asct_pkg::*;
#(
   parameter int DATA_PERIOD_OSC = DATA_PERIOD_OSC_DEF
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire asct_pins_t  pins,
   input  wire logic [23:0] sample_data,
   output logic             dout,
   output logic             dout_oe,
   output logic             conversion_ready_n,
   output logic             cal_busy,
   output logic [7:0]       config_out
);
   if (DATA_PERIOD_OSC < 32 || DATA_PERIOD_OSC > 65536) begin : g_bad_period
      $error("DATA_PERIOD_OSC out of range");
   end

   typedef struct packed {
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  filt;
      logic        sclk_q;
      logic [7:0]  osc_cnt;
      logic        osc_tick;
      logic [15:0] per_cnt;
      asct_phase_t phase;
      logic [2:0]  bitcnt;
      logic [7:0]  shin;
      logic [23:0] shout;
      logic [4:0]  outcnt;
      logic        dout;
      logic        drive;
      logic [23:0] result;
      logic [7:0]  cfg;
      logic        cont;
      logic [3:0]  cal_left;
      logic        ready_n;
   } asct_main_st_t;

   localparam asct_main_st_t ST_RST = '{
      s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, filt: PINS_IDLE,
      phase: ASCT_CMD, cfg: CONFIG_RST, ready_n: 1'b1, default: '0};

   asct_main_st_t st;
   asct_main_st_t next_st;
   logic          pattern_done;
   logic          sclk_rise;
   logic          boundary;
   logic          byte_done;
   logic [7:0]    byte_in;
   logic          pin_rst;

   assign sclk_rise = st.filt[PIN_SCLK] & ~st.sclk_q & ~st.filt[PIN_CS_N];
   assign boundary  = st.osc_tick && (st.per_cnt == 16'(DATA_PERIOD_OSC - 1));
   assign byte_done = sclk_rise && (st.bitcnt == 3'h7);
   assign byte_in   = {st.shin[6:0], st.filt[PIN_DIN]};
   assign pin_rst   = ~st.filt[PIN_RESET_N];

   ////////////////////////////////////////////////////////////////////////////
   // reset pattern watcher sees the filtered clock regardless of chip select
   asct_sclk_reset_det asct_sclk_reset_det_inst (
      .clk          (clk),
      .sys_rst      (sys_rst | pin_rst),
      .osc_tick     (st.osc_tick),
      .sclk         (st.filt[PIN_SCLK]),
      .pattern_done (pattern_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st    = st;
      // three-stage synchronisers; a change counts once stages two and three agree
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < 4; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.filt[i] = st.s3[i];
         end
      end
      next_st.sclk_q = st.filt[PIN_SCLK];

      // oscillator period tick and conversion period
      next_st.osc_tick = (st.osc_cnt == 8'(OSC_DIV_CYC - 1));
      next_st.osc_cnt  = next_st.osc_tick ? 8'h00 : st.osc_cnt + 8'h01;
      if (st.osc_tick) begin
         next_st.per_cnt = boundary ? 16'h0000 : st.per_cnt + 16'h0001;
      end

      // new conversion result; ready held high while calibrating
      if (boundary) begin
         next_st.result = sample_data;
         if (st.cal_left != 4'h0) begin
            next_st.cal_left = st.cal_left - 4'h1;
            next_st.ready_n  = (st.cal_left != 4'h1);
         end else begin
            next_st.ready_n = 1'b0;
            if (st.cont && st.phase == ASCT_CMD && st.bitcnt == 3'h0 && !st.filt[PIN_CS_N]) begin
               next_st.shout  = sample_data;
               next_st.outcnt = RESULT_BITS;
               next_st.phase  = ASCT_RESP;
            end
         end
      end

      // serial clock rising edge, chip selected
      if (sclk_rise) begin
         unique case (st.phase)
            ASCT_CMD: begin
               next_st.drive  = 1'b0;
               next_st.shin   = byte_in;
               next_st.bitcnt = st.bitcnt + 3'h1;
               // commands during calibration are dropped, not queued
               if (byte_done && st.cal_left == 4'h0) begin
                  unique case (byte_in)
                     OP_READ_RESULT: begin
                        next_st.shout   = st.result;
                        next_st.outcnt  = RESULT_BITS;
                        next_st.phase   = ASCT_RESP;
                        // a result landing in the same cycle keeps ready low
                        next_st.ready_n = ~boundary;
                     end
                     OP_READ_RESULT_CONTINUOUS: next_st.cont = 1'b1;
                     OP_STOP_CONTINUOUS_READ:   next_st.cont = 1'b0;
                     OP_READ_CONFIG_REGS: begin
                        next_st.shout  = {st.cfg, 16'h0000};
                        next_st.outcnt = CONFIG_BITS;
                        next_st.phase  = ASCT_RESP;
                     end
                     OP_WRITE_CONFIG_REGS: next_st.phase = ASCT_WDATA;
                     OP_INTERNAL_OFFSET_CAL, OP_INTERNAL_GAIN_CAL,
                     OP_SYSTEM_OFFSET_CAL, OP_SYSTEM_GAIN_CAL: begin
                        next_st.cal_left = CAL_PERIODS;
                        next_st.ready_n  = 1'b1;
                        next_st.cont     = 1'b0;
                     end
                     OP_SERIAL_RESET: begin
                        next_st.cont = 1'b0;
                        next_st.cfg  = CONFIG_RST;
                     end
                     default: next_st.phase = ASCT_CMD;  // unknown op ignored
                  endcase
               end
            end
            ASCT_WDATA: begin
               next_st.shin   = byte_in;
               next_st.bitcnt = st.bitcnt + 3'h1;
               if (byte_done) begin
                  next_st.cfg   = byte_in;
                  next_st.phase = ASCT_CMD;
               end
            end
            ASCT_RESP: begin
               next_st.dout   = st.shout[23];
               next_st.shout  = {st.shout[22:0], 1'b0};
               next_st.outcnt = st.outcnt - 5'h01;
               next_st.drive  = 1'b1;
               if (st.outcnt == 5'h01) begin
                  next_st.phase = ASCT_CMD;
               end
            end
         endcase
      end

      // chip select high ends any transfer and frees the output
      if (st.filt[PIN_CS_N]) begin
         next_st.phase  = ASCT_CMD;
         next_st.bitcnt = 3'h0;
         next_st.drive  = 1'b0;
      end

      // reset pattern: serial state and decoder back to idle
      if (pattern_done) begin
         next_st.phase  = ASCT_CMD;
         next_st.bitcnt = 3'h0;
         next_st.drive  = 1'b0;
         next_st.cont   = 1'b0;
         next_st.cfg    = CONFIG_RST;
      end

      // reset pin clears all but the synchronisers, which must see its release, and the osc_cnt/osc_tick divider
      if (pin_rst) begin
         next_st          = ST_RST;
         next_st.s1       = pins;
         next_st.s2       = st.s1;
         next_st.s3       = st.s2;
         next_st.filt     = st.filt;
         next_st.filt[PIN_RESET_N] = (st.s2[PIN_RESET_N] == st.s3[PIN_RESET_N]) ?
                                     st.s3[PIN_RESET_N] : st.filt[PIN_RESET_N];
         next_st.osc_cnt  = st.osc_cnt;
         next_st.osc_tick = st.osc_tick;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; enable gated by the filtered select so release needs no clock edge
   assign dout               = st.dout;
   assign dout_oe            = st.drive & ~st.filt[PIN_CS_N];
   assign conversion_ready_n = st.ready_n;
   assign cal_busy           = (st.cal_left != 4'h0);
   assign config_out         = st.cfg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_cs_release_out: assert property (
      st.filt[PIN_CS_N] |=> !st.drive && !dout_oe)
      else $error("data out still driven after chip select high");
   a_cal_ready_high: assert property (
      (st.cal_left != 4'h0 && !(boundary && st.cal_left == 4'h1) && !pin_rst)
      |=> conversion_ready_n)
      else $error("ready low during calibration");
   a_cal_cmd_refused: assert property (
      (byte_done && st.phase == ASCT_CMD && st.cal_left != 4'h0 && !pin_rst
       && !st.filt[PIN_CS_N])
      |=> st.phase == ASCT_CMD && (st.cal_left != 4'h0 || $past(boundary)))
      else $error("command taken during calibration");
   a_cal_done_ready: assert property (
      (boundary && st.cal_left == 4'h1 && !pin_rst)
      |=> !conversion_ready_n && st.cal_left == 4'h0)
      else $error("ready not low at calibration end");
   a_pin_reset_all: assert property (
      pin_rst |=> st.phase == ASCT_CMD && st.cal_left == 4'h0 && !st.cont
      && st.cfg == CONFIG_RST && conversion_ready_n)
      else $error("reset pin left state behind");
   a_pattern_reset: assert property (
      (pattern_done && !pin_rst)
      |=> st.phase == ASCT_CMD && st.bitcnt == 3'h0 && !st.cont && !dout_oe)
      else $error("reset pattern did not reset serial port");
   c_cal_complete: cover property (boundary && st.cal_left == 4'h1);
   c_result_read: cover property (sclk_rise && st.phase == ASCT_RESP && st.outcnt == 5'h01);
   c_config_write: cover property (byte_done && st.phase == ASCT_WDATA);
endmodule : asct_serial_port
`default_nettype wire

// file: include/asct_pkg.sv
// shared constants and types for the serial command timing block
`default_nettype none
package asct_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // clock and oscillator timing
   localparam int CLK_PERIOD_NS = 20;   // system clock, 50 mhz
   localparam int OSC_PERIOD_NS = 200;  // one oscillator period
   // cycles per oscillator period, rounded up so no window is shortened
   localparam int OSC_DIV_CYC   = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_PERIOD_OSC_DEF = 1024;  // conversion period in osc periods

   ////////////////////////////////////////////////////////////////////////////
   // serial-clock reset pattern windows, in oscillator periods
   localparam int              PW_W        = 12;
   localparam logic [PW_W-1:0] PW_MAX      = 12'hfff;
   localparam logic [PW_W-1:0] RST_HI1_MIN = 12'h12c;  // 300
   localparam logic [PW_W-1:0] RST_HI1_MAX = 12'h1f4;  // 500
   localparam logic [PW_W-1:0] RST_LO_MIN  = 12'h005;  // 5
   localparam logic [PW_W-1:0] RST_HI2_MIN = 12'h226;  // 550
   localparam logic [PW_W-1:0] RST_HI2_MAX = 12'h2ee;  // 750
   localparam logic [PW_W-1:0] RST_HI3_MIN = 12'h41a;  // 1050
   localparam logic [PW_W-1:0] RST_HI3_MAX = 12'h4e2;  // 1250

   ////////////////////////////////////////////////////////////////////////////
   // calibration, frame lengths, reset values
   localparam logic [3:0] CAL_PERIODS = 4'h7;
   localparam logic [4:0] RESULT_BITS = 5'h18;
   localparam logic [4:0] CONFIG_BITS = 5'h08;
   localparam logic [7:0] CONFIG_RST  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // command op codes
   localparam logic [7:0] OP_READ_RESULT           = 8'h01;
   localparam logic [7:0] OP_READ_RESULT_CONTINUOUS = 8'h03;
   localparam logic [7:0] OP_STOP_CONTINUOUS_READ  = 8'h0f;
   localparam logic [7:0] OP_READ_CONFIG_REGS      = 8'h10;
   localparam logic [7:0] OP_WRITE_CONFIG_REGS     = 8'h50;
   localparam logic [7:0] OP_INTERNAL_OFFSET_CAL   = 8'hf1;
   localparam logic [7:0] OP_INTERNAL_GAIN_CAL     = 8'hf2;
   localparam logic [7:0] OP_SYSTEM_OFFSET_CAL     = 8'hf3;
   localparam logic [7:0] OP_SYSTEM_GAIN_CAL       = 8'hf4;
   localparam logic [7:0] OP_SERIAL_RESET          = 8'hfe;

   ////////////////////////////////////////////////////////////////////////////
   // pin bundle and its bit positions
   typedef struct packed {
      logic reset_n;
      logic cs_n;
      logic sclk;
      logic din;
   } asct_pins_t;
   localparam int         PIN_RESET_N = 3;
   localparam int         PIN_CS_N    = 2;
   localparam int         PIN_SCLK    = 1;
   localparam int         PIN_DIN     = 0;
   localparam logic [3:0] PINS_IDLE   = 4'hc;

   typedef enum logic [2:0] {
      ASCT_CMD   = 3'h1,
      ASCT_WDATA = 3'h2,
      ASCT_RESP  = 3'h4
   } asct_phase_t;
endpackage : asct_pkg
`default_nettype wire

// file: rtl/asct_sclk_reset_det.sv
// serial-clock reset pattern detector
`timescale 1ns/1ps
`default_nettype none
module asct_sclk_reset_det
   import asct_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic osc_tick,
   input  wire logic sclk,
   output logic      pattern_done
);
   typedef struct packed {
      logic [1:0]      stage;
      logic [PW_W-1:0] hcnt;
      logic [PW_W-1:0] lcnt;
      logic            sclk_q;
      logic            done;
   } asct_det_st_t;

   asct_det_st_t st;
   asct_det_st_t next_st;
   logic         rise;
   logic         fall;
   logic         in1;
   logic         in2;
   logic         in3;

   assign rise = sclk & ~st.sclk_q;
   assign fall = ~sclk & st.sclk_q;
   assign in1  = (st.hcnt >= RST_HI1_MIN) && (st.hcnt <= RST_HI1_MAX);
   assign in2  = (st.hcnt >= RST_HI2_MIN) && (st.hcnt <= RST_HI2_MAX);
   assign in3  = (st.hcnt >= RST_HI3_MIN) && (st.hcnt <= RST_HI3_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // width counters saturate so a stuck clock never wraps into a window
   always_comb begin
      next_st        = st;
      next_st.done   = 1'b0;
      next_st.sclk_q = sclk;
      if (sclk && osc_tick && st.hcnt != PW_MAX) begin
         next_st.hcnt = st.hcnt + 12'h001;
      end
      if (!sclk && osc_tick && st.lcnt != PW_MAX) begin
         next_st.lcnt = st.lcnt + 12'h001;
      end
      if (rise) begin
         next_st.hcnt = '0;
         if (st.lcnt < RST_LO_MIN) begin
            next_st.stage = 2'h0;
         end
      end
      if (fall) begin
         next_st.lcnt = '0;
         unique case (st.stage)
            2'h0: next_st.stage = in1 ? 2'h1 : 2'h0;
            2'h1: next_st.stage = in2 ? 2'h2 : (in1 ? 2'h1 : 2'h0);
            2'h2: begin
               next_st.stage = in1 ? 2'h1 : 2'h0;
               next_st.done  = in3;
            end
            default: next_st.stage = 2'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '{sclk_q: 1'b0, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign pattern_done = st.done;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_first_pulse_win: assert property (
      (fall && st.stage == 2'h0 && !in1) |=> (st.stage == 2'h0))
      else $error("first pulse outside window advanced pattern");
   a_low_gap_min: assert property (
      (rise && st.lcnt < RST_LO_MIN) |=> (st.stage == 2'h0))
      else $error("short low gap kept pattern alive");
   a_second_pulse_win: assert property (
      (fall && st.stage == 2'h1 && !in2) |=> (st.stage != 2'h2))
      else $error("second pulse outside window accepted");
   a_third_pulse_done: assert property (
      (fall && st.stage == 2'h2 && in3) |=> pattern_done ##1 !pattern_done)
      else $error("third qualifying pulse did not finish pattern");
   c_pattern_done: cover property (pattern_done);
endmodule : asct_sclk_reset_det
`default_nettype wire

// file: sim/asct_host_model.sv
// host-side model driving the serial port pins of the converter
`timescale 1ns/1ps
`default_nettype none
module asct_host_model
   import asct_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  dout,
   output asct_pins_t pins
);
   ////////////////////////////////////////////////////////////////////////////
   // idle pins: reset released, deselected, serial clock parked low
   initial pins = PINS_IDLE;

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // one 160 ns clock pulse; dout read late in the low phase, where it has settled
   task automatic pulse(output logic bit_seen);
      pins.sclk <= 1'b1;
      tick(4);
      pins.sclk <= 1'b0;
      tick(3);
      @(negedge clk) bit_seen = dout;
      @(posedge clk);
   endtask : pulse

   // msb first; din settles 3 clk before each rise to clear the pin filter
   task automatic xfer_byte(input logic [7:0] b);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         pins.din <= b[i];
         tick(3);
         pulse(x);
      end
   endtask : xfer_byte

   task automatic read_bits(input int n, output logic [23:0] v);
      logic b;
      v = '0;
      for (int i = 0; i < n; i++) begin
         pulse(b);
         v = {v[22:0], b};
      end
   endtask : read_bits

   // host-side waits after a command, in oscillator periods
   task automatic gap_osc(input int n);
      tick(n * OSC_DIV_CYC);
   endtask : gap_osc

   task automatic select();
      pins.cs_n <= 1'b0;
      tick(5);
   endtask : select

   // released din shows the inverse of its last level, never a stale value
   task automatic deselect();
      pins.cs_n <= 1'b1;
      pins.din  <= ~pins.din;
      tick(6);
   endtask : deselect

   // one high pulse then a 10 osc low gap
   task automatic hi_lo(input int hi_osc);
      pins.sclk <= 1'b1;
      tick(hi_osc * OSC_DIV_CYC);
      pins.sclk <= 1'b0;
      tick(10 * OSC_DIV_CYC);
   endtask : hi_lo

   task automatic pattern(input int h1, input int h2, input int h3);
      hi_lo(h1);
      hi_lo(h2);
      hi_lo(h3);
   endtask : pattern

   task automatic pin_reset();
      pins.reset_n <= 1'b0;
      tick(10);
      pins.reset_n <= 1'b1;
      tick(6);
   endtask : pin_reset
endmodule : asct_host_model
`default_nettype wire

// file: sim/adc_serial_command_timing_tb.sv
// self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module adc_serial_command_timing_tb
   import asct_pkg::*;
;
   logic        clk;
   logic        sys_rst;
   logic [23:0] sample_data;
   asct_pins_t  pins;
   logic        dout;
   logic        dout_oe;
   logic        conversion_ready_n;
   logic        cal_busy;
   logic [7:0]  config_out;
   int          num_errors;
   int          checked;
   logic [23:0] v;

   ////////////////////////////////////////////////////////////////////////////
   // short conversion period keeps calibration runs brief
   asct_serial_port #(.DATA_PERIOD_OSC(32)) asct_serial_port_inst (
      .clk(clk), .sys_rst(sys_rst), .pins(pins), .sample_data(sample_data),
      .dout(dout), .dout_oe(dout_oe), .conversion_ready_n(conversion_ready_n),
      .cal_busy(cal_busy), .config_out(config_out));
   asct_host_model asct_host_model_inst (.clk(clk), .dout(dout), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic close_out();
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic wait_ready(input int n);
      for (int i = 0; i < n && conversion_ready_n !== 1'b0; i++) @(posedge clk);
   endtask : wait_ready

   task automatic write_cfg(input logic [7:0] d);
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_WRITE_CONFIG_REGS);
      asct_host_model_inst.xfer_byte(d);
      asct_host_model_inst.gap_osc(4);
      `CHK("config_out", d, config_out)
      asct_host_model_inst.deselect();
   endtask : write_cfg

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      `CHK("dout_oe", 1'b0, dout_oe)
      `CHK("conversion_ready_n", 1'b1, conversion_ready_n)
      `CHK("cal_busy", 1'b0, cal_busy)
      `CHK("config_out", CONFIG_RST, config_out)
   endtask : t_reset

   task automatic t_config();
      write_cfg(8'ha6);
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_CONFIG_REGS);
      asct_host_model_inst.gap_osc(50);
      asct_host_model_inst.read_bits(8, v);
      `CHK("config readback", 8'ha6, v[7:0])
      `CHK("dout_oe", 1'b1, dout_oe)
      asct_host_model_inst.deselect();
      `CHK("dout_oe", 1'b0, dout_oe)
   endtask : t_config

   task automatic t_result();
      sample_data <= 24'ha3c61e;
      // a read raises ready; its next fall then marks a fresh period start
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_RESULT);
      asct_host_model_inst.deselect();
      wait_ready(400);
      `CHK("conversion_ready_n", 1'b0, conversion_ready_n)
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_RESULT);
      asct_host_model_inst.tick(6);
      `CHK("conversion_ready_n", 1'b1, conversion_ready_n)
      asct_host_model_inst.gap_osc(50);
      asct_host_model_inst.read_bits(24, v);
      `CHK("result", 24'ha3c61e, v)
      asct_host_model_inst.deselect();
   endtask : t_result

   // each calibration op; the first also tries a refused write meanwhile
   task automatic t_cal();
      logic [7:0] ops [4];
      ops = '{OP_INTERNAL_OFFSET_CAL, OP_INTERNAL_GAIN_CAL,
              OP_SYSTEM_OFFSET_CAL, OP_SYSTEM_GAIN_CAL};
      foreach (ops[k]) begin
         asct_host_model_inst.select();
         asct_host_model_inst.xfer_byte(ops[k]);
         asct_host_model_inst.tick(6);
         `CHK("cal_busy", 1'b1, cal_busy)
         `CHK("conversion_ready_n", 1'b1, conversion_ready_n)
         if (k == 0) begin
            asct_host_model_inst.xfer_byte(OP_WRITE_CONFIG_REGS);
            asct_host_model_inst.xfer_byte(8'h33);
            asct_host_model_inst.tick(6);
            `CHK("config_out", 8'ha6, config_out)
         end
         // below six conversion periods from the op byte
         asct_host_model_inst.tick(k == 0 ? 1698 : 1880);
         `CHK("cal_busy", 1'b1, cal_busy)
         wait_ready(600);
         `CHK("conversion_ready_n", 1'b0, conversion_ready_n)
         `CHK("cal_busy", 1'b0, cal_busy)
         asct_host_model_inst.deselect();
      end
   endtask : t_cal

   // out-of-window first and second pulses must leave config alone
   task automatic t_pattern();
      asct_host_model_inst.pattern(200, 650, 1150);
      `CHK("config_out", 8'ha6, config_out)
      asct_host_model_inst.pattern(400, 800, 1150);
      `CHK("config_out", 8'ha6, config_out)
      asct_host_model_inst.pattern(400, 650, 1150);
      `CHK("config_out", CONFIG_RST, config_out)
      write_cfg(8'h5a);
   endtask : t_pattern

   // continuous mode streams a new result, then is stopped; then the reset op
   task automatic t_cont();
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_RESULT);
      asct_host_model_inst.deselect();
      wait_ready(400);
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_RESULT_CONTINUOUS);
      asct_host_model_inst.gap_osc(50);
      asct_host_model_inst.read_bits(24, v);
      `CHK("continuous result", 24'ha3c61e, v)
      asct_host_model_inst.gap_osc(4);
      asct_host_model_inst.xfer_byte(OP_STOP_CONTINUOUS_READ);
      // a period passes; a stuck stream would swallow the next command
      asct_host_model_inst.tick(400);
      asct_host_model_inst.xfer_byte(OP_READ_CONFIG_REGS);
      asct_host_model_inst.gap_osc(50);
      asct_host_model_inst.read_bits(8, v);
      `CHK("config after stop", 8'h5a, v[7:0])
      asct_host_model_inst.gap_osc(4);
      asct_host_model_inst.xfer_byte(OP_SERIAL_RESET);
      asct_host_model_inst.tick(6);
      `CHK("config_out", CONFIG_RST, config_out)
      asct_host_model_inst.deselect();
   endtask : t_cont

   // deselect in mid-response releases dout
   task automatic t_abort();
      wait_ready(400);
      asct_host_model_inst.select();
      asct_host_model_inst.xfer_byte(OP_READ_RESULT);
      asct_host_model_inst.gap_osc(50);
      asct_host_model_inst.read_bits(5, v);
      `CHK("partial result", 5'h14, v[4:0])
      `CHK("dout_oe", 1'b1, dout_oe)
      asct_host_model_inst.deselect();
      `CHK("dout_oe", 1'b0, dout_oe)
   endtask : t_abort

   task automatic t_pin();
      asct_host_model_inst.pin_reset();
      `CHK("config_out", CONFIG_RST, config_out)
      `CHK("conversion_ready_n", 1'b1, conversion_ready_n)
      write_cfg(8'h3c);
      // a second system reset in mid-run, then the port must work again
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      `CHK("config_out", CONFIG_RST, config_out)
      repeat (6) @(posedge clk);
      write_cfg(8'hc3);
   endtask : t_pin

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: full run needs about 82000 clk
   initial begin
      repeat (95000) @(posedge clk);
      num_errors++;
      close_out();
   end

   initial begin
      sys_rst     = 1'b1;
      sample_data = 24'h5c39e1;
      num_errors  = 0;
      checked     = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      t_reset();
      t_config();
      t_result();
      t_cal();
      t_pattern();
      t_cont();
      t_abort();
      t_pin();
      close_out();
   end
endmodule : adc_serial_command_timing_tb
`undef CHK
`default_nettype wire
